// ==== src/dmau_pkg.sv ====
package dmau_pkg;
  localparam logic [1:0]  PHASE_LAST  = 2'h3;
  localparam logic [5:0]  CLKS_PER_MC = 6'h04;
  localparam logic [5:0]  MIN_MC      = 6'h02;
  localparam logic [5:0]  ALE_CLKS    = 6'h02;
  localparam logic [5:0]  ADDR_CLKS   = 6'h04;
  localparam logic [5:0]  SRAM_CLKS   = 6'h04;
  localparam logic [15:0] XRAM_LAST   = 16'h03ff;
  localparam int          XRAM_WORDS  = 1024;
  localparam logic        XRAM_EN_RST = 1'b0;

  typedef struct packed {
    logic        write;
    logic        code;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } dmau_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_INT  = 3'b010,
    ST_EXT  = 3'b100
  } dmau_state_t;
endpackage

// ==== src/dmau_top.sv ====
`timescale 1ns/1ps
// How it works
// - machine cycle is four core clocks; accesses start on phase zero.
// - external move lasts two to nine machine cycles, chosen by mc_sel.
// - 1 KB on-chip sram answers data moves at 0000h..03ffh.
// - code fetches never reach the on-chip sram.
// - low 1 KB goes to sram only while the enable bit is set.
// - reset clears the enable bit so all moves go outside.
// - sram is its own array, unrelated to scratchpad storage.
// - low port carries multiplexed address and data during bus use.
// - bus use drives both levels; otherwise low port is open drain.
// - high port drives upper address bits during bus use.
// - write strobe for data writes, read strobe for data reads.
// - addresses above 03ffh always go to the external bus.
// - address latch strobe pulses while low address byte is on port.
module dmau_top import dmau_pkg::*; (
  input  wire logic      core_clk,
  input  wire logic      resetn,
  input  wire logic      clk_en,
  input  wire logic      req_valid,
  input  dmau_req_t      req,
  input  wire logic [2:0] mc_sel,
  input  wire logic      xram_en_wr,
  input  wire logic      xram_en_wdata,
  input  wire logic [7:0] gp_p0_out,
  input  wire logic [7:0] ad_i,
  output logic           done_q,
  output logic [7:0]     rdata_q,
  output logic           onchip_xram_enable_q,
  output logic [7:0]     p0_pin_q,
  output logic [7:0]     ad_o_q,
  output logic [7:0]     ad_oe_q,
  output logic [7:0]     addr_hi_o_q,
  output logic [7:0]     addr_hi_oe_q,
  output logic           ale_q,
  output logic           wr_n_q,
  output logic           rd_n_q,
  output logic           psen_n_q
);
  dmau_state_t state_q;
  dmau_req_t   req_q;
  logic [1:0]  phase_q;
  logic [5:0]  cyc_q;
  logic [5:0]  total_q;
  logic [5:0]  last;
  logic [7:0]  ad_meta_q;
  logic        take;
  logic        to_int;
  logic        strobe;
  logic        ext;
  // separate store, no shared decode with any scratchpad
  logic [7:0]  mem [0:XRAM_WORDS-1];

  assign last   = total_q - 6'h01;
  assign ext    = (state_q == ST_EXT);
  assign take   = req_valid && (state_q == ST_IDLE) && (phase_q == PHASE_LAST);
  assign to_int = onchip_xram_enable_q && !req.code && (req.addr <= XRAM_LAST);
  assign strobe = ext && (cyc_q >= ADDR_CLKS) && (cyc_q < last);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= 2'h0;
    end else if (clk_en) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      onchip_xram_enable_q <= XRAM_EN_RST;
    end else if (clk_en && xram_en_wr) begin
      onchip_xram_enable_q <= xram_en_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      req_q   <= '0;
      total_q <= 6'(MIN_MC * CLKS_PER_MC);
    end else if (clk_en && take) begin
      req_q   <= req;
      total_q <= 6'((6'(mc_sel) + MIN_MC) * CLKS_PER_MC);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cyc_q   <= 6'h00;
    end else if (clk_en) begin
      case (state_q)
        ST_IDLE: begin
          cyc_q <= 6'h00;
          if (take) begin
            state_q <= to_int ? ST_INT : ST_EXT;
          end
        end
        ST_INT: begin
          cyc_q <= cyc_q + 6'h01;
          if (cyc_q == SRAM_CLKS - 6'h01) begin
            state_q <= ST_IDLE;
          end
        end
        ST_EXT: begin
          cyc_q <= cyc_q + 6'h01;
          if (cyc_q == last) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (clk_en && state_q == ST_INT && cyc_q == 6'h00 && req_q.write) begin
      mem[req_q.addr[9:0]] <= req_q.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      done_q  <= 1'b0;
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      done_q <= ((state_q == ST_INT) && (cyc_q == SRAM_CLKS - 6'h01)) ||
                (ext && (cyc_q == last));
      if (state_q == ST_INT && cyc_q == 6'h00 && !req_q.write) begin
        rdata_q <= mem[req_q.addr[9:0]];
      end else if (ext && cyc_q == last && !req_q.write) begin
        rdata_q <= p0_pin_q;
      end
    end
  end

  // pin samples pass two flops before use
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ad_meta_q <= 8'h00;
      p0_pin_q  <= 8'h00;
    end else if (clk_en) begin
      ad_meta_q <= ad_i;
      p0_pin_q  <= ad_meta_q;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ale_q    <= 1'b0;
      wr_n_q   <= 1'b1;
      rd_n_q   <= 1'b1;
      psen_n_q <= 1'b1;
    end else if (clk_en) begin
      ale_q    <= ext && (cyc_q < ALE_CLKS);
      wr_n_q   <= !(strobe && req_q.write && !req_q.code);
      rd_n_q   <= !(strobe && !req_q.write && !req_q.code);
      psen_n_q <= !(strobe && req_q.code);
    end
  end

  // push-pull on bus, open drain otherwise
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ad_o_q       <= 8'h00;
      ad_oe_q      <= 8'h00;
      addr_hi_o_q  <= 8'h00;
      addr_hi_oe_q <= 8'h00;
    end else if (clk_en) begin
      if (ext) begin
        addr_hi_o_q  <= req_q.addr[15:8];
        addr_hi_oe_q <= 8'hff;
        if (cyc_q < ADDR_CLKS) begin
          ad_o_q  <= req_q.addr[7:0];
          ad_oe_q <= 8'hff;
        end else if (req_q.write && !req_q.code) begin
          ad_o_q  <= req_q.wdata;
          ad_oe_q <= 8'hff;
        end else begin
          ad_o_q  <= 8'h00;
          ad_oe_q <= 8'h00;
        end
      end else begin
        // open drain: only ever pull low
        ad_o_q       <= 8'h00;
        ad_oe_q      <= ~gp_p0_out;
        addr_hi_o_q  <= 8'h00;
        addr_hi_oe_q <= 8'h00;
      end
    end
  end

  // checks run on enabled cycles only, so a frozen core does not skew counts
  default clocking cb @(posedge core_clk iff clk_en); endclocking
  default disable iff (!resetn);

  logic       any_strb;
  logic [5:0] low_cnt_q;
  assign any_strb = !wr_n_q || !rd_n_q || !psen_n_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt_q <= 6'h00;
    end else if (clk_en) begin
      low_cnt_q <= any_strb ? low_cnt_q + 6'h01 : 6'h00;
    end
  end

  sequence s_ale_hi;
    (ale_q && ad_oe_q == 8'hff)[*2];
  endsequence
  sequence s_ale_end;
    !ale_q && !any_strb;
  endsequence

  property p_start_aligned;
    (state_q != ST_IDLE) && $past(state_q == ST_IDLE) |-> phase_q == 2'h0;
  endproperty
  a_start_aligned: assert property (p_start_aligned) else $error("access off phase");
  property p_ext_len;
    $past(ext) && !ext |-> ($past(cyc_q) + 6'h01 == total_q) && total_q >= 6'h08 &&
                          total_q <= 6'h24 && done_q;
  endproperty
  a_ext_len: assert property (p_ext_len) else $error("bad access length");
  property p_low_int;
    take && to_int |=> state_q == ST_INT ##1 ale_q == 1'b0 && !any_strb;
  endproperty
  a_low_int: assert property (p_low_int) else $error("sram access left chip");
  property p_code_out;
    take && req.code |=> ext;
  endproperty
  a_code_out: assert property (p_code_out) else $error("code fetch hit sram");
  property p_high_out;
    take && req.addr > XRAM_LAST |=> ext;
  endproperty
  a_high_out: assert property (p_high_out) else $error("upper address kept inside");
  property p_rst_dis;
    $rose(resetn) |-> !onchip_xram_enable_q;
  endproperty
  a_rst_dis: assert property (p_rst_dis) else $error("sram enabled out of reset");
  property p_ale;
    $rose(ale_q) |-> s_ale_hi ##1 s_ale_end;
  endproperty
  a_ale: assert property (p_ale) else $error("latch pulse wrong");
  property p_strb_len;
    $fell(any_strb) |-> low_cnt_q == total_q - ADDR_CLKS - 6'h01;
  endproperty
  a_strb_len: assert property (p_strb_len) else $error("strobe width wrong");
  property p_addr_hold;
    any_strb && $past(any_strb) |-> $stable(addr_hi_o_q) && addr_hi_oe_q == 8'hff;
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in strobe");
  property p_od_idle;
    (state_q == ST_IDLE) ##1 (state_q == ST_IDLE) |-> ad_o_q == 8'h00;
  endproperty
  a_od_idle: assert property (p_od_idle) else $error("port drove high when idle");
endmodule

// ==== dv/dmau_ext_mem.sv ====
`timescale 1ns/1ps
module dmau_ext_mem (
  input  wire logic       core_clk,
  input  wire logic [7:0] ad_o,
  input  wire logic [7:0] ad_oe,
  input  wire logic [7:0] addr_hi,
  input  wire logic       ale,
  input  wire logic       wr_n,
  input  wire logic       rd_n,
  input  wire logic       psen_n,
  output logic [7:0]      ad_i
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  lo_q;
  logic [7:0]  last_q = 8'h00;
  logic [15:0] a;
  assign a = {addr_hi, lo_q};
  always_ff @(posedge core_clk) if (ale) lo_q <= ad_o;
  always_ff @(posedge core_clk) if (!wr_n) mem[a] <= ad_o;
  always_ff @(posedge core_clk) last_q <= ad_i;
  // drive on read
  // floating bits show the inverse of the last level, never a stale copy
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ad_i[i] = ad_oe[i] ? ad_o[i] : (!rd_n || !psen_n) ? mem[a][i] : ~last_q[i];
    end
  end
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench import dmau_pkg::*; ;
  logic       core_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       clk_en = 1'b1;
  logic       req_valid = 1'b0;
  dmau_req_t  req = '0;
  logic [2:0] mc_sel = 3'h0;
  logic       xram_en_wr = 1'b0;
  logic       xram_en_wdata = 1'b0;
  logic       done_q, onchip_xram_enable_q, ale_q, wr_n_q, rd_n_q, psen_n_q;
  logic [7:0] ad_i, rdata_q, p0_pin_q, ad_o_q, ad_oe_q, addr_hi_o_q, addr_hi_oe_q;
  int         n_fail = 0;
  int         check_count = 0;
  int         cyc = 0;

  dmau_top u_dmau_top (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .req_valid(req_valid), .req(req), .mc_sel(mc_sel), .xram_en_wr(xram_en_wr),
    .xram_en_wdata(xram_en_wdata), .gp_p0_out(8'h0f), .ad_i(ad_i), .done_q(done_q),
    .rdata_q(rdata_q), .onchip_xram_enable_q(onchip_xram_enable_q), .p0_pin_q(p0_pin_q),
    .ad_o_q(ad_o_q), .ad_oe_q(ad_oe_q), .addr_hi_o_q(addr_hi_o_q),
    .addr_hi_oe_q(addr_hi_oe_q), .ale_q(ale_q), .wr_n_q(wr_n_q), .rd_n_q(rd_n_q),
    .psen_n_q(psen_n_q));
  dmau_ext_mem u_dmau_ext_mem (.core_clk(core_clk), .ad_o(ad_o_q), .ad_oe(ad_oe_q),
    .addr_hi(addr_hi_o_q), .ale(ale_q), .wr_n(wr_n_q), .rd_n(rd_n_q),
    .psen_n(psen_n_q), .ad_i(ad_i));

  initial forever #12.5 core_clk = ~core_clk;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ceiling well above the ~600 cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic chk_val(string nm, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_cnt(string nm, int e, int g);
    check_count++;
    if (g != e) begin
      n_fail++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic acc(logic w, c, logic [15:0] a, logic [7:0] d, logic [2:0] s,
      output logic [7:0] rd, output int sp, ns, na, nb, output logic [2:0] m);
    int k;
    int ta;
    ta = -1;
    ns = 0;
    na = 0;
    nb = 0;
    m = 3'h0;
    req = '{w, c, a, d};
    mc_sel = s;
    req_valid = 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge core_clk);
      #1;
      if (ale_q === 1'b1) begin
        na++;
        if (ta < 0) ta = k;
        if (ad_o_q !== a[7:0]) nb++;
      end
      m = m | {~psen_n_q, ~rd_n_q, ~wr_n_q};
      if ((wr_n_q & rd_n_q & psen_n_q) !== 1'b1) begin
        ns++;
        if (addr_hi_o_q !== a[15:8] || addr_hi_oe_q !== 8'hff) nb++;
        if (wr_n_q === 1'b0 && ad_oe_q !== 8'hff) nb++;
      end
      if (done_q === 1'b1) break;
    end
    if (k == 200) nb++;
    sp = k - ta;
    rd = rdata_q;
    req_valid = 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  task automatic ext(logic w, c, logic [15:0] a, logic [7:0] d, logic [2:0] s, logic [7:0] e);
    logic [7:0] rd;
    logic [2:0] m;
    int sp, ns, na, nb, t;
    t = 4 * (s + 2);
    acc(w, c, a, d, s, rd, sp, ns, na, nb, m);
    chk_cnt("span", t - 1, sp);
    chk_cnt("strobe", t - 5, ns);
    chk_cnt("ale", 2, na);
    chk_cnt("addr", 0, nb);
    chk_val("kind", {13'h0, c ? 3'h4 : w ? 3'h1 : 3'h2}, {13'h0, m});
    if (!w) chk_val("rdata", {8'h0, e}, {8'h0, rd});
    if (w && !c) chk_val("pin", {8'h0, d}, {8'h0, p0_pin_q});
  endtask

  task automatic intl(logic w, logic [15:0] a, logic [7:0] d, logic [7:0] e);
    logic [7:0] rd;
    logic [2:0] m;
    int sp, ns, na, nb;
    acc(w, 1'b0, a, d, 3'h0, rd, sp, ns, na, nb, m);
    chk_cnt("int bus", 0, ns + na + nb);
    if (!w) chk_val("int rdata", {8'h0, e}, {8'h0, rd});
  endtask

  task automatic set_en(logic v);
    xram_en_wdata = v;
    xram_en_wr = 1'b1;
    @(posedge core_clk);
    #1;
    xram_en_wr = 1'b0;
    chk_val("enable", {15'h0, v}, {15'h0, onchip_xram_enable_q});
  endtask

  task automatic t_reset();
    repeat (2) @(posedge core_clk);
    #1;
    chk_val("rst en", 16'h0, {15'h0, onchip_xram_enable_q});
    chk_val("rst strobes", 16'h7, {13'h0, wr_n_q, rd_n_q, psen_n_q});
    @(posedge core_clk);
    #1;
    resetn = 1'b1;
    @(posedge core_clk);
    #1;
    chk_val("idle oe", 16'h00f0, {8'h0, ad_oe_q});
    $display("test reset done");
  endtask

  task automatic t_ext();
    ext(1'b1, 1'b0, 16'h0010, 8'ha5, 3'h0, 8'h0);
    for (int s = 0; s < 8; s++) begin
      ext(1'b1, 1'b0, 16'h1200 | 16'(s), 8'h30 + 8'(s), 3'(s), 8'h0);
      ext(1'b0, 1'b0, 16'h1200 | 16'(s), 8'h0, 3'(7 - s), 8'h30 + 8'(s));
    end
    $display("test external done");
  endtask

  task automatic t_int();
    set_en(1'b1);
    intl(1'b1, 16'h0010, 8'h5a, 8'h0);
    intl(1'b0, 16'h0010, 8'h0, 8'h5a);
    intl(1'b1, 16'h03ff, 8'h3c, 8'h0);
    intl(1'b0, 16'h03ff, 8'h0, 8'h3c);
    ext(1'b1, 1'b0, 16'h0400, 8'hc3, 3'h0, 8'h0);
    ext(1'b0, 1'b0, 16'h0400, 8'h0, 3'h1, 8'hc3);
    ext(1'b0, 1'b1, 16'h0010, 8'h0, 3'h0, 8'ha5);
    set_en(1'b0);
    ext(1'b0, 1'b0, 16'h0010, 8'h0, 3'h2, 8'ha5);
    $display("test internal done");
  endtask

  task automatic t_ctl();
    set_en(1'b1);
    // frozen core must ignore an enable write
    clk_en = 1'b0;
    @(posedge core_clk);
    #1;
    xram_en_wdata = 1'b0;
    xram_en_wr = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    xram_en_wr = 1'b0;
    @(posedge core_clk);
    #1;
    clk_en = 1'b1;
    chk_val("frozen en", 16'h1, {15'h0, onchip_xram_enable_q});
    // second reset in mid run must drop the enable again
    resetn = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk_val("mid rst en", 16'h0, {15'h0, onchip_xram_enable_q});
    resetn = 1'b1;
    ext(1'b0, 1'b0, 16'h0010, 8'h0, 3'h0, 8'ha5);
    $display("test control done");
  endtask

  initial begin
    t_reset();
    t_ext();
    t_int();
    t_ctl();
    wrap_up();
  end
endmodule
